// *** flmc_dev.sv ***
// flash led device: serial slave, register file, mode control, timeout, gain steps
// Contract
// RULE1 - step gain up when headroom falls low
// RULE2 - hold gain until disable, then restart low
// RULE3 - flash, torch, indicator, shutdown by register
// RULE4 - synchronise trigger and rf limit inputs
// RULE5 - trigger low: follow register; rf limits flash
// RULE6 - trigger high, rf low: timed flash
// RULE7 - trigger and rf high: timed torch
// RULE8 - start is sda fall while scl high
// RULE9 - stop is sda rise while scl high
// RULE10 - only master makes start and stop
// RULE11 - bus busy from start until stop
// RULE12 - repeated start restarts address reception
// RULE13 - sda changes only while scl low
// RULE14 - eight bits msb first, then ack slot
// RULE15 - master clocks ack and releases sda
// RULE16 - slave pulls sda low on ninth pulse
// RULE17 - first byte: address 53h plus direction
// RULE18 - write: register select then data byte
// RULE19 - mode register low bits select mode
// RULE20 - mode bit 3 ignores flash trigger
// RULE21 - timeout code picks 60 to 1100 ms
// RULE22 - timed out sink off until re-enable
// RULE23 - foreign address: no ack, wait start
// RULE24 - early stop leaves registers unchanged
`timescale 1ns/1ps
module flmc_dev import flmc_pkg::*; #(
    parameter int unsigned MS_CYCLES = MS_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    flmc_if.dev link,
    input wire logic flash_trigger,
    input wire logic rf_pulse_limit,
    input wire logic sink_headroom_sense,
    output flmc_led_e led_mode,
    output logic [3:0] led_level,
    output logic sink_on,
    output flmc_gain_e gain,
    output logic timed_out,
    output logic bus_busy,
    output logic [3:0] mode_reg,
    output logic [3:0] flash_code,
    output logic [3:0] torch_code,
    output logic [3:0] timeout_code
);
    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [1:0] trg_sy;
        logic [1:0] rf_sy;
        logic [1:0] hd_sy;
        flmc_sl_e sl;
        logic busy;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic [7:0] shreg;
        logic [7:0] reg_sel;
        logic rd_xfer;
        logic ack_drv;
        logic [3:0] mode;
        logic [3:0] flash;
        logic [3:0] torch;
        logic [3:0] tout;
        flmc_gain_e gain;
        logic [7:0] settle;
        logic [TO_CNT_W-1:0] to_cnt;
        logic timed_out;
        flmc_led_e led;
        logic [3:0] level;
        logic sink_on;
    } flmc_dev_s;

    flmc_dev_s s_ff;
    flmc_dev_s nxt_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic strobe_eff;
    logic active;
    logic timed;
    flmc_led_e reg_led;
    flmc_led_e req_led;
    logic [TO_CNT_W-1:0] to_limit;

    function automatic flmc_led_e decode_mode(input logic [3:0] m);
        if (!m[MODE_EN_BIT]) begin // see RULE19
            decode_mode = LED_OFF;
        end else if (m[MODE_FLASH_BIT]) begin
            decode_mode = LED_FLASH;
        end else if (m[MODE_IND_BIT]) begin
            decode_mode = LED_IND;
        end else begin
            decode_mode = LED_TORCH;
        end
    endfunction

    // edges seen on second and third stages only
    assign scl_rise = s_ff.scl_sy[1] & ~s_ff.scl_sy[2];
    assign scl_fall = ~s_ff.scl_sy[1] & s_ff.scl_sy[2];
    assign start_det = s_ff.scl_sy[1] & s_ff.scl_sy[2] & s_ff.sda_sy[2] & ~s_ff.sda_sy[1]; // see RULE8
    assign stop_det = s_ff.scl_sy[1] & s_ff.scl_sy[2] & ~s_ff.sda_sy[2] & s_ff.sda_sy[1]; // see RULE9

    assign strobe_eff = s_ff.trg_sy[1] & ~s_ff.mode[MODE_INHIBIT_BIT]; // see RULE20
    assign reg_led = decode_mode(s_ff.mode); // see RULE3
    assign active = strobe_eff | s_ff.mode[MODE_EN_BIT];
    assign timed = strobe_eff | (reg_led == LED_FLASH);
    assign to_limit = TO_CNT_W'(32'(flmc_to_ms(s_ff.tout[2:0])) * MS_CYCLES); // see RULE21

    always_comb begin
        if (strobe_eff) begin
            req_led = s_ff.rf_sy[1] ? LED_TORCH : LED_FLASH; // see RULE6 see RULE7
        end else if (reg_led == LED_FLASH && s_ff.rf_sy[1]) begin
            req_led = LED_TORCH; // see RULE5
        end else begin
            req_led = reg_led; // see RULE5
        end
    end

    always_comb begin
        nxt_s = s_ff;
        // pins are asynchronous, two stages before any use
        nxt_s.scl_sy = {s_ff.scl_sy[1:0], link.scl};
        nxt_s.sda_sy = {s_ff.sda_sy[1:0], link.sda};
        nxt_s.trg_sy = {s_ff.trg_sy[0], flash_trigger}; // see RULE4
        nxt_s.rf_sy = {s_ff.rf_sy[0], rf_pulse_limit}; // see RULE4
        nxt_s.hd_sy = {s_ff.hd_sy[0], sink_headroom_sense};

        if (start_det) begin
            // first and repeated start behave the same
            nxt_s.sl = SL_RECV; // see RULE12
            nxt_s.busy = 1'b1; // see RULE11
            nxt_s.bit_cnt = 4'h0;
            nxt_s.byte_idx = 2'h0;
            nxt_s.ack_drv = 1'b0;
        end else if (stop_det) begin
            // data is only stored once all eight bits are in
            nxt_s.sl = SL_IDLE; // see RULE24
            nxt_s.busy = 1'b0; // see RULE11
            nxt_s.ack_drv = 1'b0;
        end else begin
            case (s_ff.sl)
                SL_RECV: begin
                    if (scl_rise && s_ff.bit_cnt != 4'h8) begin
                        nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_sy[1]}; // see RULE14
                        nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                    end else if (scl_fall && s_ff.bit_cnt == 4'h8) begin
                        // ack is raised after scl fell, so sda moves only with scl low
                        nxt_s.bit_cnt = 4'h0;
                        nxt_s.sl = SL_ACK;
                        nxt_s.ack_drv = 1'b1; // see RULE16 see RULE13
                        case (s_ff.byte_idx)
                            2'h0: begin
                                if (s_ff.shreg[7:1] != DEV_ADDR) begin // see RULE17
                                    nxt_s.sl = SL_WAIT; // see RULE23
                                    nxt_s.ack_drv = 1'b0;
                                end
                                nxt_s.rd_xfer = s_ff.shreg[0];
                            end
                            2'h1: nxt_s.reg_sel = s_ff.shreg; // see RULE18
                            default: begin
                                case (s_ff.reg_sel) // see RULE18
                                    REG_MODE: nxt_s.mode = s_ff.shreg[3:0];
                                    REG_FLASH: nxt_s.flash = s_ff.shreg[3:0];
                                    REG_TORCH: nxt_s.torch = s_ff.shreg[3:0];
                                    REG_TIMEOUT: nxt_s.tout = s_ff.shreg[3:0];
                                    default: nxt_s.mode = s_ff.mode;
                                endcase
                            end
                        endcase
                    end
                end
                SL_ACK: begin
                    if (scl_fall) begin
                        // reads have no data path; the master sees all ones
                        nxt_s.ack_drv = 1'b0;
                        nxt_s.sl = s_ff.rd_xfer ? SL_WAIT : SL_RECV;
                        if (s_ff.byte_idx != 2'h2) begin
                            nxt_s.byte_idx = s_ff.byte_idx + 2'h1;
                        end
                    end
                end
                SL_WAIT: nxt_s.sl = SL_WAIT;
                SL_IDLE: nxt_s.sl = SL_IDLE;
                default: nxt_s.sl = SL_IDLE;
            endcase
        end

        // timeout: counts while a flash request stands, cleared only by disable
        if (!active) begin
            nxt_s.to_cnt = '0;
            nxt_s.timed_out = 1'b0; // see RULE22
        end else if (!timed) begin
            nxt_s.to_cnt = '0;
        end else if (!s_ff.timed_out) begin
            if (s_ff.to_cnt >= to_limit - TO_CNT_W'(1)) begin
                nxt_s.timed_out = 1'b1; // see RULE22 see RULE6 see RULE7
            end else begin
                nxt_s.to_cnt = s_ff.to_cnt + TO_CNT_W'(1);
            end
        end

        nxt_s.led = s_ff.timed_out ? LED_OFF : req_led;
        nxt_s.sink_on = ~s_ff.timed_out & (req_led != LED_OFF); // see RULE22
        case (req_led)
            LED_FLASH: nxt_s.level = s_ff.flash;
            LED_TORCH: nxt_s.level = s_ff.torch;
            default: nxt_s.level = IND_LEVEL;
        endcase

        // settle time keeps one dip from skipping a gain step
        if (!active) begin
            nxt_s.gain = GAIN_1X; // see RULE2
            nxt_s.settle = 8'h0;
        end else if (s_ff.settle != 8'h0) begin
            nxt_s.settle = s_ff.settle - 8'h1;
        end else if (s_ff.hd_sy[1] && s_ff.sink_on) begin
            case (s_ff.gain)
                GAIN_1X: nxt_s.gain = GAIN_1P5X; // see RULE1
                GAIN_1P5X: nxt_s.gain = GAIN_2X; // see RULE1
                default: nxt_s.gain = GAIN_2X; // see RULE2
            endcase
            nxt_s.settle = 8'(GAIN_SETTLE_CYC);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_ff <= '{scl_sy: 3'h7, sda_sy: 3'h7, trg_sy: 2'h0, rf_sy: 2'h0, hd_sy: 2'h0,
                      sl: SL_IDLE, busy: 1'b0, bit_cnt: 4'h0, byte_idx: 2'h0, shreg: 8'h00,
                      reg_sel: 8'h00, rd_xfer: 1'b0, ack_drv: 1'b0, mode: RST_MODE,
                      flash: RST_FLASH, torch: RST_TORCH, tout: RST_TIMEOUT, gain: GAIN_1X,
                      settle: 8'h00, to_cnt: '0, timed_out: 1'b0, led: LED_OFF,
                      level: 4'h0, sink_on: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = ~s_ff.ack_drv; // see RULE16
    assign led_mode = s_ff.led;
    assign led_level = s_ff.level;
    assign sink_on = s_ff.sink_on;
    assign gain = s_ff.gain;
    assign timed_out = s_ff.timed_out;
    assign bus_busy = s_ff.busy;
    assign mode_reg = s_ff.mode;
    assign flash_code = s_ff.flash;
    assign torch_code = s_ff.torch;
    assign timeout_code = s_ff.tout;
endmodule // flmc_dev

// *** flmc_pkg.sv ***
// shared constants and types for the flash led controller link and both ends
package flmc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam logic [6:0] DEV_ADDR = 7'h53;

    // device register offsets and reset values (low four bits are stored)
    localparam logic [7:0] REG_MODE = 8'h10;
    localparam logic [7:0] REG_FLASH = 8'hb0;
    localparam logic [7:0] REG_TORCH = 8'ha0;
    localparam logic [7:0] REG_TIMEOUT = 8'hc0;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [3:0] RST_FLASH = 4'ha;
    localparam logic [3:0] RST_TORCH = 4'h7;
    localparam logic [3:0] RST_TIMEOUT = 4'hb;
    localparam int MODE_EN_BIT = 0;
    localparam int MODE_FLASH_BIT = 1;
    localparam int MODE_IND_BIT = 2;
    localparam int MODE_INHIBIT_BIT = 3;
    localparam logic [3:0] IND_LEVEL = 4'h0;

    // headroom comparator lives in the analog part; threshold kept for reference
    localparam int unsigned HEADROOM_MV = 350;
    localparam int unsigned GAIN_SETTLE_NS = 1000;
    localparam int unsigned GAIN_SETTLE_CYC = (GAIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned TO_CNT_W = 27;

    // host side bit timing: scl period well above the 2.5 us minimum
    localparam int unsigned SCL_MIN_NS = 2500;
    localparam int unsigned SCL_PERIOD_NS = 10000;
    localparam int unsigned SCL_QTR_CYC = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;

    // host command registers
    localparam logic [7:0] HREG_TARGET = 8'h00;
    localparam logic [7:0] HREG_DATA = 8'h04;
    localparam logic [7:0] HREG_CTRL = 8'h08;
    localparam logic [7:0] HREG_STATUS = 8'h0c;
    localparam int HCTRL_GO_BIT = 0;
    localparam int HSTAT_BUSY_BIT = 0;
    localparam int HSTAT_NACK_BIT = 1;

    typedef enum logic [2:0] {GAIN_1X = 3'b001, GAIN_1P5X = 3'b010, GAIN_2X = 3'b100} flmc_gain_e;
    typedef enum logic [3:0] {
        LED_OFF = 4'b0001, LED_TORCH = 4'b0010, LED_FLASH = 4'b0100, LED_IND = 4'b1000
    } flmc_led_e;
    typedef enum logic [3:0] {
        SL_IDLE = 4'b0001, SL_RECV = 4'b0010, SL_ACK = 4'b0100, SL_WAIT = 4'b1000
    } flmc_sl_e;
    typedef enum logic [3:0] {
        HM_IDLE = 4'b0001, HM_START = 4'b0010, HM_BITS = 4'b0100, HM_STOP = 4'b1000
    } flmc_hm_e;

    function automatic logic [10:0] flmc_to_ms(input logic [2:0] code);
        case (code)
            3'h0: flmc_to_ms = 11'd60;
            3'h1: flmc_to_ms = 11'd125;
            3'h2: flmc_to_ms = 11'd250;
            3'h3: flmc_to_ms = 11'd375;
            3'h4: flmc_to_ms = 11'd500;
            3'h5: flmc_to_ms = 11'd625;
            3'h6: flmc_to_ms = 11'd750;
            default: flmc_to_ms = 11'd1100;
        endcase
    endfunction
endpackage

// *** flmc_if.sv ***
// two-wire serial link between host controller and flash led device
`timescale 1ns/1ps
interface flmc_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // open drain with pull-up: low only while an enabled driver pulls low
    assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

    modport host(output scl, output host_sda_o, output host_sda_oe_n, input sda);
    modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// *** flmc_host.sv ***
// host controller: writes one device register per command over the serial link
`timescale 1ns/1ps
module flmc_host import flmc_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    flmc_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    typedef struct packed {
        logic [1:0] sda_sy;
        flmc_hm_e st;
        logic [7:0] qcnt;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [1:0] bytn;
        logic [7:0] shreg;
        logic scl;
        logic sda_rel;
        logic nack;
        logic [7:0] target;
        logic [7:0] data;
        logic [31:0] rdata;
    } flmc_host_s;

    flmc_host_s s_ff;
    flmc_host_s nxt_s;
    logic tick;
    logic idle;

    assign tick = s_ff.qcnt == 8'(SCL_QTR_CYC - 1);
    assign idle = s_ff.st == HM_IDLE;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.sda_sy = {s_ff.sda_sy[0], link.sda};
        nxt_s.qcnt = (idle || tick) ? 8'h00 : s_ff.qcnt + 8'h01;
        if (tick) begin
            nxt_s.ph = s_ff.ph + 2'h1;
        end

        if (wr && idle) begin
            case (addr)
                HREG_TARGET: nxt_s.target = wdata[7:0];
                HREG_DATA: nxt_s.data = wdata[7:0];
                HREG_CTRL: begin
                    if (wdata[HCTRL_GO_BIT]) begin
                        nxt_s.st = HM_START;
                        nxt_s.ph = 2'h0;
                        nxt_s.nack = 1'b0;
                    end
                end
                default: nxt_s.target = s_ff.target;
            endcase
        end
        if (rd) begin
            case (addr)
                HREG_TARGET: nxt_s.rdata = {24'h000000, s_ff.target};
                HREG_DATA: nxt_s.rdata = {24'h000000, s_ff.data};
                HREG_STATUS: nxt_s.rdata = {30'h0, s_ff.nack, ~idle};
                default: nxt_s.rdata = 32'h00000000;
            endcase
        end

        case (s_ff.st)
            HM_IDLE: begin
                nxt_s.scl = 1'b1;
                nxt_s.sda_rel = 1'b1;
            end
            HM_START: begin
                if (tick) begin
                    if (s_ff.ph == 2'h0) begin
                        nxt_s.sda_rel = 1'b0; // see RULE8 see RULE10
                    end else begin
                        nxt_s.scl = 1'b0;
                        nxt_s.st = HM_BITS;
                        nxt_s.ph = 2'h0;
                        nxt_s.bitn = 4'h0;
                        nxt_s.bytn = 2'h0;
                        nxt_s.shreg = {DEV_ADDR, 1'b0}; // see RULE17
                    end
                end
            end
            HM_BITS: begin
                if (tick) begin
                    case (s_ff.ph)
                        2'h0: nxt_s.sda_rel = (s_ff.bitn == 4'h8) | s_ff.shreg[7]; // see RULE13 see RULE15
                        2'h1: nxt_s.scl = 1'b1;
                        2'h2: begin
                            if (s_ff.bitn == 4'h8 && s_ff.sda_sy[1]) begin
                                nxt_s.nack = 1'b1;
                            end
                        end
                        default: begin
                            nxt_s.scl = 1'b0;
                            nxt_s.shreg = {s_ff.shreg[6:0], 1'b0}; // see RULE14
                            nxt_s.bitn = s_ff.bitn + 4'h1;
                            if (s_ff.bitn == 4'h8) begin
                                nxt_s.bitn = 4'h0;
                                nxt_s.bytn = s_ff.bytn + 2'h1;
                                nxt_s.shreg = (s_ff.bytn == 2'h0) ? s_ff.target : s_ff.data; // see RULE18
                                if (s_ff.nack || s_ff.bytn == 2'h2) begin
                                    nxt_s.st = HM_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            HM_STOP: begin
                if (tick) begin
                    case (s_ff.ph)
                        2'h0: nxt_s.sda_rel = 1'b0;
                        2'h1: nxt_s.scl = 1'b1;
                        default: begin
                            nxt_s.sda_rel = 1'b1; // see RULE9 see RULE10
                            nxt_s.st = HM_IDLE;
                        end
                    endcase
                end
            end
            default: nxt_s.st = HM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_ff <= '{sda_sy: 2'h3, st: HM_IDLE, qcnt: 8'h00, ph: 2'h0, bitn: 4'h0, bytn: 2'h0,
                      shreg: 8'h00, scl: 1'b1, sda_rel: 1'b1, nack: 1'b0, target: 8'h00,
                      data: 8'h00, rdata: 32'h00000000};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.scl = s_ff.scl;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = s_ff.sda_rel;
    assign rdata = s_ff.rdata;
endmodule // flmc_host

// *** flmc_link_monitor.sv ***
// wire-level checker for the two-wire link between host and device
`timescale 1ns/1ps
module flmc_link_monitor import flmc_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic busy;
    logic [3:0] cnt;
    logic [1:0] byte_ix;
    logic [7:0] shreg;
    logic [11:0] ack_len;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    assign start_seen = scl & scl_q & sda_q & ~sda;
    assign stop_seen = scl & scl_q & ~sda_q & sda;
    assign scl_rise = scl & ~scl_q;
    // idle levels after reset so a release never looks like a start
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            busy <= 1'b0;
            cnt <= 4'h0;
            byte_ix <= 2'h0;
            shreg <= 8'h00;
            ack_len <= 12'h000;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            busy <= start_seen | (busy & ~stop_seen);
            if (start_seen) begin
                cnt <= 4'h0;
                byte_ix <= 2'h0;
            end else if (scl_rise) begin
                cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
                byte_ix <= (cnt == 4'h9 && byte_ix != 2'h3) ? byte_ix + 2'h1 : byte_ix;
                shreg <= {shreg[6:0], sda};
            end
            ack_len <= dev_sda_oe_n ? 12'h000 : ack_len + {11'h000, ack_len != 12'hfff};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_ack_scl_low: assert property ($fell(dev_sda_oe_n) |-> !scl && cnt == 4'h8)
        else $error("ack began outside the low phase after bit eight");
    a_dev_stable_high: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
        else $error("device changed sda while scl high");
    a_ack_on_ninth: assert property ($rose(scl) && cnt == 4'h8 && byte_ix != 2'h0 |-> !dev_sda_oe_n)
        else $error("register or data byte not acknowledged");
    a_addr_match_ack: assert property ($rose(scl) && cnt == 4'h8 && byte_ix == 2'h0
        |-> dev_sda_oe_n == (shreg[7:1] != DEV_ADDR))
        else $error("address acknowledge does not follow address match");
    a_ack_len_bound: assert property (ack_len <= 12'd1100)
        else $error("device held acknowledge past the ninth pulse");
    a_idle_silent: assert property (!busy |-> dev_sda_oe_n)
        else $error("device drove sda while bus free");
    a_host_ack_free: assert property ($rose(scl) && cnt == 4'h8 |-> host_sda_oe_n [*3])
        else $error("host held sda during acknowledge pulse");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*5])
        else $error("scl high phase too short");
    // a start or stop edge on sda must come from the host releasing or pulling
    a_master_conds: assert property (start_seen || stop_seen |-> $changed(host_sda_oe_n))
        else $error("start or stop not made by the host");
    c_start: cover property (start_seen);
    c_data_ack: cover property ($fell(dev_sda_oe_n) && byte_ix == 2'h2);
    c_stop: cover property (stop_seen);
endmodule // flmc_link_monitor

// *** flash_led_mode_i2c_ctrl_test.sv ***
// self-checking bench: host register port drives the link into the device
`timescale 1ns/1ps
module flash_led_mode_i2c_ctrl_test import flmc_pkg::*;;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic flash_trigger = 1'b0;
    logic rf_pulse_limit = 1'b0;
    logic sink_headroom_sense = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] s;
    flmc_led_e led_mode;
    flmc_gain_e gain;
    logic [3:0] led_level;
    logic [3:0] mode_reg;
    logic [3:0] flash_code;
    logic [3:0] torch_code;
    logic [3:0] timeout_code;
    logic sink_on;
    logic timed_out;
    logic bus_busy;
    int failures = 0;
    int compares = 0;
    always #5 clk_sys = ~clk_sys;
    flmc_if link();
    // ten cycles per ms keeps the 375 ms default timeout at 3750 cycles
    flmc_dev #(.MS_CYCLES(10)) flmc_dev_i(.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
        .flash_trigger(flash_trigger), .rf_pulse_limit(rf_pulse_limit),
        .sink_headroom_sense(sink_headroom_sense), .led_mode(led_mode), .led_level(led_level),
        .sink_on(sink_on), .gain(gain), .timed_out(timed_out), .bus_busy(bus_busy),
        .mode_reg(mode_reg), .flash_code(flash_code), .torch_code(torch_code),
        .timeout_code(timeout_code));
    flmc_host flmc_host_i(.clk_sys(clk_sys), .reset_n(reset_n), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    flmc_link_monitor flmc_link_monitor_i(.clk_sys(clk_sys), .reset_n(reset_n), .scl(link.scl),
        .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic hw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    // read data stand from the cycle after the strobe until the next read
    task automatic hr(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 s = rdata;
    endtask
    task automatic dev_write(input logic [7:0] r, input logic [7:0] d);
        int n;
        hw(HREG_TARGET, r);
        hw(HREG_DATA, d);
        hw(HREG_CTRL, 8'h01);
        hr(HREG_STATUS);
        chk(s[HSTAT_BUSY_BIT], 1'b1);
        // start goes out a quarter bit after go; the device must see the bus busy
        cyc(300);
        chk(bus_busy, 1'b1);
        n = 0;
        while (s[HSTAT_BUSY_BIT] !== 1'b0 && n < 20000) begin
            hr(HREG_STATUS);
            n++;
        end
        if (n >= 20000) begin
            failures++;
            wrap_up();
        end
        chk(s[HSTAT_NACK_BIT], 1'b0);
        cyc(4);
        chk(bus_busy, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        cyc(4);
        chk(mode_reg, RST_MODE);
        chk(flash_code, RST_FLASH);
        chk(torch_code, RST_TORCH);
        chk(timeout_code, RST_TIMEOUT);
        chk(led_mode, LED_OFF);
        chk(gain, GAIN_1X);
        hr(HREG_STATUS);
        chk(s, 32'h0);
        dev_write(REG_MODE, 8'h03);
        chk(mode_reg, 4'h3);
        chk(led_mode, LED_FLASH);
        chk(led_level, RST_FLASH);
        chk(sink_on, 1'b1);
        @(posedge clk_sys) sink_headroom_sense <= 1'b1;
        cyc(8);
        chk(gain, GAIN_1P5X);
        cyc(110);
        chk(gain, GAIN_2X);
        @(posedge clk_sys) sink_headroom_sense <= 1'b0;
        @(posedge clk_sys) rf_pulse_limit <= 1'b1;
        cyc(8);
        chk(gain, GAIN_2X);
        chk(led_mode, LED_TORCH);
        chk(led_level, RST_TORCH);
        @(posedge clk_sys) rf_pulse_limit <= 1'b0;
        cyc(4000);
        chk(timed_out, 1'b1);
        chk(sink_on, 1'b0);
        $display("test register flash done");
        dev_write(REG_MODE, 8'h00);
        chk(timed_out, 1'b0);
        chk(gain, GAIN_1X);
        chk(led_mode, LED_OFF);
        @(posedge clk_sys) flash_trigger <= 1'b1;
        // two sync stages: no reaction yet two edges after the pin moved
        cyc(2);
        chk(led_mode, LED_OFF);
        cyc(6);
        chk(led_mode, LED_FLASH);
        @(posedge clk_sys) rf_pulse_limit <= 1'b1;
        cyc(8);
        chk(led_mode, LED_TORCH);
        @(posedge clk_sys) rf_pulse_limit <= 1'b0;
        cyc(3670);
        chk(timed_out, 1'b0);
        cyc(100);
        chk(timed_out, 1'b1);
        chk(led_mode, LED_OFF);
        @(posedge clk_sys) flash_trigger <= 1'b0;
        cyc(8);
        chk(timed_out, 1'b0);
        $display("test trigger flash done");
        dev_write(REG_MODE, 8'h0d);
        chk(led_mode, LED_IND);
        chk(led_level, IND_LEVEL);
        @(posedge clk_sys) flash_trigger <= 1'b1;
        cyc(8);
        chk(led_mode, LED_IND);
        @(posedge clk_sys) flash_trigger <= 1'b0;
        $display("test trigger inhibit done");
        wrap_up();
    end
endmodule // flash_led_mode_i2c_ctrl_test
